//--- rtc_irq_alarm_pkg.sv
`default_nettype none
package rtc_irq_alarm_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] IER_OFFSET = 8'h00;
    localparam logic [7:0] COUNTDOWN_OFFSET = 8'h04;
    localparam logic [7:0] SUMMER_HOURS_OFFSET = 8'h08;
    localparam logic [7:0] SUMMER_MONTHS_OFFSET = 8'h0c;
    localparam logic [7:0] SUMMER_DAYS_OFFSET = 8'h10;
    localparam logic [7:0] CONTROL_OFFSET = 8'h14;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;

    // Interrupt bit positions, shared by enable and status
    localparam int TAMPER_BIT = 0;
    localparam int COUNTDOWN_BIT = 1;
    localparam int ALARM_BIT = 2;
    localparam int DAY_BIT = 3;
    localparam int HOUR_BIT = 4;
    localparam int MINUTE_BIT = 5;
    localparam int SECOND_BIT = 6;
    localparam int HALF_SECOND_BIT = 7;
    localparam int PERIODIC_LSB = 8;

    // Control register fields
    localparam int SOFT_RESET_BIT = 0;
    localparam int SUMMER_ENABLE_BIT = 1;
    localparam int ALARM_MODE_LSB = 2;

    // Field positions of the summer time registers
    localparam int BEGIN_LSB = 8;
    localparam int FINISH_LSB = 0;

    // Reset values, and the last minute of the hour
    localparam logic [15:0] IER_RESET = 16'h0001;
    localparam logic [15:0] STATUS_RESET = 16'h0001;
    localparam logic [7:0] COUNTDOWN_RESET = 8'h00;
    localparam logic [4:0] HOUR_RESET = 5'h00;
    localparam logic [3:0] MONTH_RESET = 4'h1;
    localparam logic [4:0] DAY_RESET = 5'h01;
    localparam logic [5:0] LAST_MINUTE = 6'h3b;

    typedef enum logic [1:0] {
        ALARM_DAILY = 2'b00,
        ALARM_MONTHLY = 2'b01,
        ALARM_YEARLY = 2'b10,
        ALARM_ONCE = 2'b11
    } alarm_mode_e;

    typedef struct packed {
        logic [7:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } time_s;

    typedef struct packed {
        logic [7:0] periodic;
        logic half_second;
        logic second;
        logic minute;
        logic hour;
        logic day;
        logic tamper;
    } tick_s;

endpackage : rtc_irq_alarm_pkg
`default_nettype wire

//--- rtc_irq_alarm_countdown_dst.sv
// Function
// R01: Sixteen enable bits: periodic 15:8, half-second 7 down to tamper 0.
// R02: Clearing an enable leaves status flags alone; flags set regardless.
// R03: Tamper enable set by power-on reset, kept through software reset.
// R04: Software reset clears every enable except tamper.
// R05: One interrupt output, OR of all enabled pending sources.
// R06: Alarm mode selects daily, monthly, yearly or one-time compare.
// R07: Countdown decrements only on the minute tick.
// R08: Writing zero to the countdown does nothing.
// R09: Countdown reaching zero raises the expiry flag.
// R10: Software reset clears the countdown.
// R11: Countdown read returns the live counter value.
// R12: Count in bits 7:0, zero means disabled, upper bits read zero.
// R13: Software should load the countdown right after a minute flag.
// R14: Summer time registers writable only while summer time is disabled.
// R15: Hours register: begin hour 12:8, finish hour 4:0, rest zero.
// R16: Hardware checks minute 59; software programs the hour before change.
// R17: Months register: begin month 11:8, finish month 3:0, rest zero.
// R18: Days register: begin day 12:8, finish day 4:0, rest zero.
// R19: Summer time registers survive a software reset.
// R20: Writing one clears a status flag and its interrupt contribution.
// R21: At begin setting hour advances by one, at finish it falls back.
`default_nettype none
module rtc_irq_alarm_countdown_dst
    import rtc_irq_alarm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire tick_s i_tick,
    input wire time_s i_time,
    input wire time_s i_alarm,
    output logic o_irq,
    output logic o_dst_advance,
    output logic o_dst_fallback,
    output logic o_summer_time_enable,
    output logic [1:0] o_alarm_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wdat,
                                            input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res;
    endfunction : merge16

    // One register's write strobe
    function automatic logic write_to(input logic strobe, input logic [7:0] adr, input logic [7:0] target);
        return strobe && adr == target;
    endfunction : write_to

    // Counters sit on a programmed month, day and hour
    function automatic logic on_setting(input time_s now, input logic [3:0] month, input logic [4:0] day,
                                        input logic [4:0] hour);
        return now.month == month && now.day == day && now.hour == hour;
    endfunction : on_setting

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic ack_q;
    logic access;
    logic wr;
    logic rd_any;
    logic soft_reset;
    logic wr_ier;
    logic wr_countdown;
    logic wr_hours;
    logic wr_months;
    logic wr_days;
    logic wr_control;
    logic wr_status;

    assign access = i_wb_cyc && i_wb_stb && !ack_q;
    assign wr = access && i_wb_we;
    assign rd_any = access && !i_wb_we;

    assign wr_ier = write_to(wr, i_wb_adr, IER_OFFSET);
    assign wr_countdown = write_to(wr, i_wb_adr, COUNTDOWN_OFFSET);
    assign wr_hours = write_to(wr, i_wb_adr, SUMMER_HOURS_OFFSET);
    assign wr_months = write_to(wr, i_wb_adr, SUMMER_MONTHS_OFFSET);
    assign wr_days = write_to(wr, i_wb_adr, SUMMER_DAYS_OFFSET);
    assign wr_control = write_to(wr, i_wb_adr, CONTROL_OFFSET);
    assign wr_status = write_to(wr, i_wb_adr, STATUS_OFFSET);

    // Every request is answered, mapped or not, so a stray address cannot stall the bus
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    assign o_wb_ack = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // Control: alarm mode, summer time enable, software reset strobe

    logic [15:0] control_q;
    logic [15:0] control_wr;

    assign control_wr = merge16(control_q, i_wb_dat, i_wb_sel);
    // Strobe is not stored; it acts for the one write cycle only
    assign soft_reset = wr_control && i_wb_sel[0] && i_wb_dat[SOFT_RESET_BIT];

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            control_q <= 16'h0000;
        end else if (soft_reset) begin
            control_q <= 16'h0000;
        end else if (wr_control) begin
            control_q <= {12'h000, control_wr[ALARM_MODE_LSB +: 2], control_wr[SUMMER_ENABLE_BIT], 1'b0};
        end
    end

    logic summer_en;
    alarm_mode_e alarm_mode;

    assign summer_en = control_q[SUMMER_ENABLE_BIT];
    assign alarm_mode = alarm_mode_e'(control_q[ALARM_MODE_LSB +: 2]);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_summer_time_enable <= 1'b0;
            o_alarm_mode <= 2'b00;
        end else begin
            o_summer_time_enable <= summer_en;
            o_alarm_mode <= alarm_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt enable

    logic [15:0] ier_q;
    logic [15:0] ier_wr;

    assign ier_wr = merge16(ier_q, i_wb_dat, i_wb_sel);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ier_q <= IER_RESET; // see R03
        end else if (soft_reset) begin
            ier_q <= {IER_RESET[15:1], ier_q[TAMPER_BIT]}; // see R04 see R03
        end else if (wr_ier) begin
            ier_q <= ier_wr; // see R01
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm compare

    logic match;
    logic match_q;
    logic same_clock;
    logic same_day;
    logic same_month;
    logic same_year;

    assign same_clock = i_time.second == i_alarm.second && i_time.minute == i_alarm.minute
        && i_time.hour == i_alarm.hour;
    assign same_day = i_time.day == i_alarm.day;
    assign same_month = i_time.month == i_alarm.month;
    assign same_year = i_time.year == i_alarm.year;

    // Each mode widens the previous one by one more counter
    always_comb begin
        match = 1'b0;
        unique case (alarm_mode) // see R06
            ALARM_DAILY: match = same_clock;
            ALARM_MONTHLY: match = same_clock && same_day;
            ALARM_YEARLY: match = same_clock && same_day && same_month;
            ALARM_ONCE: match = same_clock && same_day && same_month && same_year;
        endcase
    end

    // Flag only on the entry into a match, not for its whole second
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Minute countdown

    logic [7:0] count_q;
    logic expire;
    logic count_wr;

    // A zero load is dropped, so the running count is not disturbed
    assign count_wr = wr_countdown && i_wb_sel[0] && i_wb_dat[7:0] != 8'h00;
    assign expire = i_tick.minute && count_q == 8'h01 && !count_wr; // see R09

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_q <= COUNTDOWN_RESET;
        end else if (soft_reset) begin
            count_q <= COUNTDOWN_RESET; // see R10
        end else if (count_wr) begin
            count_q <= i_wb_dat[7:0]; // see R08
        end else if (i_tick.minute && count_q != 8'h00) begin
            count_q <= count_q - 8'h01; // see R07
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags

    logic [15:0] status_q;
    logic [15:0] events;
    logic [15:0] clear_mask;

    assign events = {i_tick.periodic, i_tick.half_second, i_tick.second, i_tick.minute, i_tick.hour,
                     i_tick.day, match && !match_q, expire, i_tick.tamper};
    assign clear_mask = wr_status ? merge16(16'h0000, i_wb_dat, i_wb_sel) : 16'h0000;

    // Set beats a clear landing in the same cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_q <= STATUS_RESET;
        end else if (soft_reset) begin
            status_q <= {15'h0000, status_q[TAMPER_BIT] | events[TAMPER_BIT]};
        end else begin
            status_q <= (status_q & ~clear_mask) | events; // see R20 see R02
        end
    end

    // One cycle behind the flags, so the pin never glitches on a decode
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_q & ier_q); // see R05 see R20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Summer time settings

    logic [4:0] begin_hour_q;
    logic [4:0] finish_hour_q;
    logic [3:0] begin_month_q;
    logic [3:0] finish_month_q;
    logic [4:0] begin_day_q;
    logic [4:0] finish_day_q;
    logic summer_wr;
    logic [15:0] hours_rd;
    logic [15:0] months_rd;
    logic [15:0] days_rd;
    logic [15:0] hours_wr;
    logic [15:0] months_wr;
    logic [15:0] days_wr;

    assign summer_wr = wr && !summer_en; // see R14
    assign hours_rd = {3'b000, begin_hour_q, 3'b000, finish_hour_q}; // see R15
    assign months_rd = {4'h0, begin_month_q, 4'h0, finish_month_q}; // see R17
    assign days_rd = {3'b000, begin_day_q, 3'b000, finish_day_q}; // see R18
    assign hours_wr = merge16(hours_rd, i_wb_dat, i_wb_sel);
    assign months_wr = merge16(months_rd, i_wb_dat, i_wb_sel);
    assign days_wr = merge16(days_rd, i_wb_dat, i_wb_sel);

    // Only power-on reset touches these; software reset does not
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            begin_hour_q <= HOUR_RESET;
            finish_hour_q <= HOUR_RESET;
        end else if (summer_wr && wr_hours) begin // see R19
            begin_hour_q <= hours_wr[BEGIN_LSB +: 5];
            finish_hour_q <= hours_wr[FINISH_LSB +: 5];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            begin_month_q <= MONTH_RESET;
            finish_month_q <= MONTH_RESET;
        end else if (summer_wr && wr_months) begin // see R19
            begin_month_q <= months_wr[BEGIN_LSB +: 4];
            finish_month_q <= months_wr[FINISH_LSB +: 4];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            begin_day_q <= DAY_RESET;
            finish_day_q <= DAY_RESET;
        end else if (summer_wr && wr_days) begin // see R19
            begin_day_q <= days_wr[BEGIN_LSB +: 5];
            finish_day_q <= days_wr[FINISH_LSB +: 5];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Summer time change at the minute-59 rollover

    logic at_rollover;
    logic hit_begin;
    logic hit_finish;
    logic fallen_q;

    assign at_rollover = summer_en && i_tick.minute && i_time.minute == LAST_MINUTE; // see R16
    assign hit_begin = at_rollover && on_setting(i_time, begin_month_q, begin_day_q, begin_hour_q);
    assign hit_finish = at_rollover && on_setting(i_time, finish_month_q, finish_day_q, finish_hour_q) && !fallen_q;

    // Falling back repeats the finish hour; remember it so it happens once
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fallen_q <= 1'b0;
        end else if (hit_finish) begin
            fallen_q <= 1'b1;
        end else if (i_time.day != finish_day_q || i_time.month != finish_month_q) begin
            fallen_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dst_advance <= 1'b0;
            o_dst_fallback <= 1'b0;
        end else begin
            o_dst_advance <= hit_begin; // see R21
            o_dst_fallback <= hit_finish; // see R21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [15:0] rd_mux;

    // Unmapped offsets read as zero
    always_comb begin
        unique case (i_wb_adr)
            IER_OFFSET: rd_mux = ier_q;
            COUNTDOWN_OFFSET: rd_mux = {8'h00, count_q}; // see R11 see R12
            SUMMER_HOURS_OFFSET: rd_mux = hours_rd;
            SUMMER_MONTHS_OFFSET: rd_mux = months_rd;
            SUMMER_DAYS_OFFSET: rd_mux = days_rd;
            CONTROL_OFFSET: rd_mux = control_q;
            STATUS_OFFSET: rd_mux = status_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (rd_any) begin
            o_wb_dat <= {16'h0000, rd_mux};
        end
    end

endmodule : rtc_irq_alarm_countdown_dst
`default_nettype wire

//--- rtc_irq_alarm_countdown_dst_properties.sv
`default_nettype none
module rtc_irq_checker
    import rtc_irq_alarm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [31:0] o_wb_dat,
    input wire tick_s i_tick,
    input wire time_s i_time,
    input wire logic o_dst_advance,
    input wire logic o_dst_fallback,
    input wire logic o_summer_time_enable,
    input wire logic [1:0] o_alarm_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    logic take;
    assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
    ////////////////////////////////////////
    sequence ctrl_wr;
        take && i_wb_we && i_wb_sel[0] && i_wb_adr == CONTROL_OFFSET;
    endsequence
    sequence rd_ack(a);
        o_wb_ack && !i_wb_we && i_wb_adr == a;
    endsequence
    AST_ACK_NEXT: assert property (take |=> o_wb_ack)
        else $error("request not answered next cycle");
    AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_CNT_HIGH_ZERO: assert property (rd_ack(COUNTDOWN_OFFSET) |-> o_wb_dat[15:8] == 8'h00)
        else $error("countdown upper byte not zero");
    AST_HOURS_RSVD: assert property (rd_ack(SUMMER_HOURS_OFFSET) |-> !o_wb_dat[15:13] && !o_wb_dat[7:5])
        else $error("hours reserved bits set");
    AST_MONTHS_RSVD: assert property (rd_ack(SUMMER_MONTHS_OFFSET) |-> !o_wb_dat[15:12] && !o_wb_dat[7:4])
        else $error("months reserved bits set");
    AST_DAYS_RSVD: assert property (rd_ack(SUMMER_DAYS_OFFSET) |-> !o_wb_dat[15:13] && !o_wb_dat[7:5])
        else $error("days reserved bits set");
    AST_MODE_FOLLOWS: assert property (ctrl_wr |-> ##2
        o_alarm_mode == ($past(i_wb_dat[0], 2) ? 2'h0 : $past(i_wb_dat[3:2], 2)))
        else $error("alarm mode not taken from control");
    AST_SUMMER_FOLLOWS: assert property (ctrl_wr |-> ##2
        o_summer_time_enable == (!$past(i_wb_dat[0], 2) && $past(i_wb_dat[1], 2)))
        else $error("summer enable not taken from control");
    AST_DST_AT_59: assert property ((o_dst_advance || o_dst_fallback) |->
        $past(i_tick.minute) && $past(i_time.minute) == LAST_MINUTE && o_summer_time_enable)
        else $error("hour shift outside minute 59 rollover");
endmodule : rtc_irq_checker
bind rtc_irq_alarm_countdown_dst rtc_irq_checker rtc_irq_checker_inst (.i_clk, .i_resetn, .i_wb_cyc,
    .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_wb_dat, .i_tick, .i_time,
    .o_dst_advance, .o_dst_fallback, .o_summer_time_enable, .o_alarm_mode);
`default_nettype wire

//--- rtc_irq_alarm_countdown_dst_tb.sv
`default_nettype none
module rtc_irq_alarm_countdown_dst_tb
    import rtc_irq_alarm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, adv, fall, sen;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [15:0] rd;
    logic [1:0] amode;
    tick_s tick = '0;
    time_s tnow = '0, alarm_irq_en = 34'h1;
    time_s base = '{8'h05, 4'h3, 5'h09, 5'h0a, 6'h14, 6'h1e};
    int fail_count = 0, total_checks = 0, advs = 0, falls = 0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        advs += adv;
        falls += fall;
    end
    rtc_irq_alarm_countdown_dst rtc_irq_alarm_countdown_dst_inst (.i_clk(clk), .i_resetn(resetn),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_tick(tick), .i_time(tnow), .i_alarm(alarm_irq_en), .o_irq(irq),
        .o_dst_advance(adv), .o_dst_fallback(fall), .o_summer_time_enable(sen), .o_alarm_mode(amode));
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Single classic cycle; ack is sampled before the edge's own updates land
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string n, input logic [7:0] a, input logic [15:0] e);
        xfer(1'b0, a, 16'h0000);
        chk(n, e, rd);
    endtask : rdc
    task automatic pulse(input tick_s t, input time_s tm);
        @(posedge clk);
        tick <= t;
        tnow <= tm;
        @(posedge clk);
        tick <= '0;
        repeat (3) @(posedge clk);
    endtask : pulse
    function automatic time_s bump(input time_s t, input int k);
        time_s r;
        r = t;
        if (k == 0) r.hour = r.hour + 5'h01;
        if (k == 1) r.day = r.day + 5'h01;
        if (k == 2) r.month = r.month + 4'h1;
        if (k == 3) r.year = r.year + 8'h01;
        return r;
    endfunction : bump
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rdc("ier", IER_OFFSET, 16'h0001);
        rdc("status", STATUS_OFFSET, 16'h0001);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr(STATUS_OFFSET, 16'hffff);
        for (int b = 0; b < 16; b++) begin
            if (b == 1 || b == 2) continue;
            wr(IER_OFFSET, 16'h0000);
            pulse(tick_s'(b == 0 ? 14'h0001 : 14'h0001 << (b - 2)), tnow);
            rdc("flag", STATUS_OFFSET, 16'h0001 << b);
            chk("irq_off", 16'h0000, {15'h0000, irq});
            wr(IER_OFFSET, 16'h0001 << b);
            repeat (2) @(posedge clk);
            chk("irq_on", 16'h0001, {15'h0000, irq});
            wr(STATUS_OFFSET, 16'h0001 << b);
            repeat (2) @(posedge clk);
            chk("irq_clr", 16'h0000, {15'h0000, irq});
        end
        tnow <= base;
        for (int m = 0; m < 4; m++) begin
            wr(CONTROL_OFFSET, 16'(m << 2));
            wr(STATUS_OFFSET, 16'h0004);
            chk("mode", 16'(m), {14'h0000, amode});
            alarm_irq_en <= bump(base, m);
            repeat (3) @(posedge clk);
            rdc("alarm_miss", STATUS_OFFSET, 16'h0000);
            alarm_irq_en <= bump(base, m + 1);
            repeat (3) @(posedge clk);
            rdc("alarm_hit", STATUS_OFFSET, 16'h0004);
        end
        wr(CONTROL_OFFSET, 16'h0000);
        wr(STATUS_OFFSET, 16'hffff);
        pulse(14'h0008, tnow);
        wr(COUNTDOWN_OFFSET, 16'hff02);
        rdc("cnt_load", COUNTDOWN_OFFSET, 16'h0002);
        wr(COUNTDOWN_OFFSET, 16'h0000);
        rdc("cnt_zero", COUNTDOWN_OFFSET, 16'h0002);
        pulse(14'h0010, tnow);
        rdc("cnt_sec", COUNTDOWN_OFFSET, 16'h0002);
        pulse(14'h0008, tnow);
        rdc("cnt_live", COUNTDOWN_OFFSET, 16'h0001);
        pulse(14'h0008, tnow);
        rdc("expiry", STATUS_OFFSET, 16'h0062);
        wr(IER_OFFSET, 16'h0002);
        repeat (2) @(posedge clk);
        chk("irq_cnt", 16'h0001, {15'h0000, irq});
        wr(IER_OFFSET, 16'hfffe);
        wr(COUNTDOWN_OFFSET, 16'h0007);
        wr(CONTROL_OFFSET, 16'h0001);
        rdc("ier_soft", IER_OFFSET, 16'h0000);
        rdc("cnt_soft", COUNTDOWN_OFFSET, 16'h0000);
        wr(SUMMER_HOURS_OFFSET, 16'hffff);
        rdc("hours_mask", SUMMER_HOURS_OFFSET, 16'h1f1f);
        wr(SUMMER_MONTHS_OFFSET, 16'hffff);
        rdc("months_mask", SUMMER_MONTHS_OFFSET, 16'h0f0f);
        wr(SUMMER_HOURS_OFFSET, 16'h0102);
        wr(SUMMER_MONTHS_OFFSET, 16'h030a);
        wr(SUMMER_DAYS_OFFSET, 16'h191c);
        wr(CONTROL_OFFSET, 16'h0002);
        wr(SUMMER_DAYS_OFFSET, 16'h0505);
        chk("summer_en", 16'h0001, {15'h0000, sen});
        rdc("days_locked", SUMMER_DAYS_OFFSET, 16'h191c);
        pulse(14'h0008, '{8'h07, 4'h3, 5'h19, 5'h01, 6'h3a, 6'h00});
        chk("adv_58", 16'h0000, 16'(advs));
        pulse(14'h0008, '{8'h07, 4'h3, 5'h19, 5'h01, 6'h3b, 6'h00});
        pulse(14'h0008, '{8'h07, 4'ha, 5'h1c, 5'h02, 6'h3b, 6'h00});
        chk("advance", 16'h0001, 16'(advs));
        chk("fallback", 16'h0001, 16'(falls));
        pulse(14'h0008, '{8'h07, 4'ha, 5'h1c, 5'h02, 6'h3b, 6'h00});
        chk("fallback_once", 16'h0001, 16'(falls));
        wr(CONTROL_OFFSET, 16'h0001);
        rdc("hours_soft", SUMMER_HOURS_OFFSET, 16'h0102);
        wrap_up();
    end
endmodule : rtc_irq_alarm_countdown_dst_tb
`default_nettype wire
